// ===== dmtm_timer.sv
// timer with prescaler, capture, reference compare and apb registers
`timescale 1ns/1ns
`default_nettype none
module dmtm_timer
  import dmtm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer pins
  input wire logic timer_input_pin,
  output logic timer_output_pin,
  // request outputs and dma acknowledge
  output logic dma_request,
  output logic irq_request,
  input wire logic dma_ack
);
  typedef struct packed {
    logic [15:0] mode;
    logic [7:0] xmode;
    logic [31:0] refv;
    logic [31:0] capv;
    logic [31:0] cnt;
    logic [7:0] pre;
    logic [3:0] div16;
    logic rflag;
    logic cflag;
    logic out;
    logic [31:0] rdata;
  } dmtm_state_t;

  dmtm_state_t st_r, st_nxt;

  logic pin_rise, pin_fall;
  logic en, restart, mreq_en, style, dma_en, diag;
  logic [1:0] clk_sel, ce;
  logic [7:0] prescale;
  logic src_tick, tick, match, edge_ev, rst_fall;
  logic acc, wr, hit, req_any;
  logic [31:0] step, cnt_adv, rmux;

  // external input crosses into pclk here
  dmtm_sync #(
    .RST_VAL(PIN_RST)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(timer_input_pin),
    .lvl(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign en = st_r.mode[M_RST];
  assign clk_sel = st_r.mode[M_CLK +: 2];
  assign restart = st_r.mode[M_RESTART];
  assign mreq_en = st_r.mode[M_MATCH_REQ];
  assign style = st_r.mode[M_STYLE];
  assign ce = st_r.mode[M_CE +: 2];
  assign prescale = st_r.mode[M_PRESCALE +: 8];
  assign dma_en = st_r.xmode[X_DMA_EN];
  assign diag = st_r.xmode[X_DIAG];

  // count clock source select
  always_comb begin
    unique case (clk_sel)
      CLK_STOP: src_tick = 1'b0;
      CLK_SYS1: src_tick = 1'b1;
      CLK_SYS16: src_tick = (st_r.div16 == DIV16_LAST);
      CLK_PIN: src_tick = pin_fall;
    endcase
  end

  // >= so a smaller prescale written mid-count ends the period at once
  assign tick = en && src_tick && (st_r.pre >= prescale);
  assign step = diag ? STEP_DIAG : STEP_ONE;
  assign cnt_adv = (restart && (st_r.cnt == st_r.refv)) ? CNT_RST
                   : st_r.cnt + step;
  assign match = tick && (cnt_adv == st_r.refv);
  assign edge_ev = en && (((ce == CE_RISE) && pin_rise)
                  || ((ce == CE_FALL) && pin_fall)
                  || ((ce == CE_ANY) && (pin_rise || pin_fall)));

  // apb decode
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  always_comb begin
    hit = 1'b1;
    rmux = 32'h0000_0000;
    unique case (paddr)
      A_MODE: rmux = {16'h0000, st_r.mode};
      A_XMODE: rmux = {24'h00_0000, st_r.xmode};
      A_EVENT: rmux = {30'h0000_0000, st_r.rflag, st_r.cflag};
      A_REF: rmux = st_r.refv;
      A_CAPT: rmux = st_r.capv;
      A_CNT: rmux = st_r.cnt;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    rst_fall = 1'b0;
    // free-running divider, never cleared by the enable bit
    st_nxt.div16 = st_r.div16 + 4'h1;
    if (psel && !penable) begin
      st_nxt.rdata = rmux;
    end
    // writes land even while the timer is held in reset
    if (wr) begin
      unique case (paddr)
        A_MODE: begin
          st_nxt.mode = pwdata[15:0];
          rst_fall = en && !pwdata[M_RST];
        end
        A_XMODE: st_nxt.xmode = pwdata[7:0] & XMODE_MASK;
        A_EVENT: begin
          if (pwdata[E_REF]) begin
            st_nxt.rflag = 1'b0;
          end
          if (pwdata[E_EDGE]) begin
            st_nxt.cflag = 1'b0;
          end
        end
        A_REF: st_nxt.refv = pwdata;
        A_CAPT: st_nxt.capv = pwdata;
        default: ;
      endcase
    end
    if (dma_ack) begin
      st_nxt.rflag = 1'b0;
      st_nxt.cflag = 1'b0;
    end
    // counter and prescaler
    if (!en) begin
      st_nxt.cnt = CNT_RST;
      st_nxt.pre = PRE_RST;
      st_nxt.out = OUT_IDLE;
    end else if (src_tick) begin
      if (tick) begin
        st_nxt.pre = PRE_RST;
        st_nxt.cnt = cnt_adv;
      end else begin
        st_nxt.pre = st_r.pre + 8'h01;
      end
    end
    // output pin
    if (en) begin
      if (match) begin
        st_nxt.out = style ? !st_r.out : 1'b0;
      end else if (!style) begin
        st_nxt.out = OUT_IDLE;
      end
    end
    // hardware set wins over software or acknowledge clear
    if (match) begin
      st_nxt.rflag = 1'b1;
    end
    if (edge_ev) begin
      st_nxt.cflag = 1'b1;
      st_nxt.capv = st_r.cnt;
    end
    // software reset wins: events in that same cycle are dropped
    if (rst_fall) begin
      st_nxt.cnt = CNT_RST;
      st_nxt.pre = PRE_RST;
      st_nxt.capv = CAPT_RST;
      st_nxt.rflag = 1'b0;
      st_nxt.cflag = 1'b0;
      st_nxt.out = OUT_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{mode: MODE_RST, xmode: XMODE_RST, refv: REF_RST,
                capv: CAPT_RST, cnt: CNT_RST, pre: PRE_RST,
                div16: DIV16_RST, rflag: 1'b0, cflag: 1'b0,
                out: OUT_IDLE, rdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign timer_output_pin = st_r.out;
  assign req_any = st_r.cflag || (st_r.rflag && mreq_en);
  assign dma_request = dma_en && req_any;
  assign irq_request = !dma_en && req_any;

  // checks
  default clocking dmtm_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_presc_divide: assert property (
    (en && src_tick && st_r.pre < prescale && !rst_fall)
      |=> !$past(tick) && st_r.pre == $past(st_r.pre) + 8'h01)
    else $error("prescaler did not step");

  // flag path, not just the decode, so a stray capture trips it
  a_no_capture_off: assert property (
    (ce == CE_OFF && !st_r.cflag) |=> !st_r.cflag)
    else $error("capture with edge select off");

  a_rise_capture: assert property (
    (en && ce == CE_RISE && pin_rise && !rst_fall) |=> st_r.cflag)
    else $error("rising edge not captured");

  a_pulse_low: assert property (
    (match && !style && !rst_fall) |=> !timer_output_pin
      ##1 (timer_output_pin || $past(match)))
    else $error("output pulse not one cycle low");

  a_toggle_out: assert property (
    (match && style && !rst_fall)
      |=> timer_output_pin != $past(st_r.out))
    else $error("output did not toggle");

  a_ref_request: assert property (
    (st_r.rflag && mreq_en) |-> (dma_request ^ irq_request)
      && (dma_request == dma_en))
    else $error("match request misrouted");

  a_no_ref_req: assert property (
    (!st_r.cflag && !mreq_en) |-> !dma_request && !irq_request)
    else $error("request without enable");

  a_dma_gate: assert property (
    dma_request |-> dma_en)
    else $error("dma request while disabled");

  a_free_run: assert property (
    (tick && !restart && !diag && st_r.cnt == st_r.refv && !rst_fall)
      |=> st_r.cnt == $past(st_r.cnt) + STEP_ONE)
    else $error("free run did not continue");

  a_restart_zero: assert property (
    (tick && restart && st_r.cnt == st_r.refv && !rst_fall)
      |=> st_r.cnt == CNT_RST)
    else $error("restart did not clear counter");

  a_halt_count: assert property (
    !en |=> st_r.cnt == CNT_RST)
    else $error("counter moved while disabled");

  a_diag_step: assert property (
    (tick && diag && !(restart && st_r.cnt == st_r.refv) && !rst_fall)
      |=> st_r.cnt == $past(st_r.cnt) + STEP_DIAG)
    else $error("diagnostic step wrong");

  a_edge_latch: assert property (
    (edge_ev && !rst_fall)
      |=> st_r.capv == $past(st_r.cnt) && st_r.cflag)
    else $error("capture value not latched");

  a_ack_clears: assert property (
    (dma_ack && !match && !edge_ev) |=> !st_r.rflag && !st_r.cflag)
    else $error("acknowledge did not clear flags");

  a_soft_reset: assert property (
    rst_fall |=> st_r.cnt == CNT_RST && !st_r.rflag && !st_r.cflag)
    else $error("software reset incomplete");

  c_restart_match: cover property (match && restart);
  c_capture_dma: cover property (edge_ev && dma_en);
  c_toggle_out: cover property (match && style);
  c_diag_match: cover property (match && diag);
endmodule
`default_nettype wire

// ===== dmtm_pkg.sv
// constants shared by the timer mode control block
package dmtm_pkg;
  // apb address width
  localparam int APB_AW = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h00;
  localparam logic [7:0] IDX_XMODE = 8'h02;
  localparam logic [7:0] IDX_EVENT = 8'h03;
  localparam logic [7:0] IDX_REF = 8'h04;
  localparam logic [7:0] IDX_CAPT = 8'h08;
  localparam logic [7:0] IDX_CNT = 8'h0C;
  localparam logic [7:0] A_MODE = {IDX_MODE[5:0], 2'b00};
  localparam logic [7:0] A_XMODE = {IDX_XMODE[5:0], 2'b00};
  localparam logic [7:0] A_EVENT = {IDX_EVENT[5:0], 2'b00};
  localparam logic [7:0] A_REF = {IDX_REF[5:0], 2'b00};
  localparam logic [7:0] A_CAPT = {IDX_CAPT[5:0], 2'b00};
  localparam logic [7:0] A_CNT = {IDX_CNT[5:0], 2'b00};
  // timer_mode fields
  localparam int M_RST = 0;
  localparam int M_CLK = 1;
  localparam int M_RESTART = 3;
  localparam int M_MATCH_REQ = 4;
  localparam int M_STYLE = 5;
  localparam int M_CE = 6;
  localparam int M_PRESCALE = 8;
  // timer_extended_mode fields
  localparam int X_DIAG = 0;
  localparam int X_DMA_EN = 7;
  localparam logic [7:0] XMODE_MASK = 8'h81;
  // timer_event_flags fields
  localparam int E_EDGE = 0;
  localparam int E_REF = 1;
  // clock source codes
  localparam logic [1:0] CLK_STOP = 2'h0;
  localparam logic [1:0] CLK_SYS1 = 2'h1;
  localparam logic [1:0] CLK_SYS16 = 2'h2;
  localparam logic [1:0] CLK_PIN = 2'h3;
  // capture edge codes
  localparam logic [1:0] CE_OFF = 2'h0;
  localparam logic [1:0] CE_RISE = 2'h1;
  localparam logic [1:0] CE_FALL = 2'h2;
  localparam logic [1:0] CE_ANY = 2'h3;
  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0] XMODE_RST = 8'h00;
  localparam logic [31:0] REF_RST = 32'h1111_1111;
  localparam logic [31:0] CAPT_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [3:0] DIV16_RST = 4'h0;
  localparam logic OUT_IDLE = 1'b1;
  localparam logic PIN_RST = 1'b1;
  // counts
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [31:0] STEP_ONE = 32'h0000_0001;
  localparam logic [31:0] STEP_DIAG = 32'h0001_0001;
endpackage

// ===== dmtm_sync.sv
// three-flop input synchroniser with filtered edge pulses
`timescale 1ns/1ns
`default_nettype none
module dmtm_sync
  import dmtm_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous input
  input wire logic din,
  // filtered level and one-cycle edges
  output logic lvl,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
  } dmtm_sync_state_t;

  dmtm_sync_state_t st_r, st_nxt;
  logic agree;

  // sh[0] only feeds sh[1]; metastability stays out of the compare
  assign agree = (st_r.sh[1] == st_r.sh[2]);
  assign rise = agree && st_r.sh[2] && !st_r.lvl;
  assign fall = agree && !st_r.sh[2] && st_r.lvl;
  assign lvl = st_r.lvl;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sh = {st_r.sh[1:0], din};
    if (agree) begin
      st_nxt.lvl = st_r.sh[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{sh: {3{RST_VAL}}, lvl: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== dmtm_dma_model.sv
// dma controller model that acknowledges timer requests
`timescale 1ns/1ns
`default_nettype none
module dmtm_dma_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request, answer delay and acknowledge
  input wire logic dma_request,
  input wire logic [3:0] delay,
  output logic dma_ack
);
  logic [3:0] wait_r;
  // one ack per request, then rearm once the ack has landed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      dma_ack <= 1'b0;
    end else begin
      dma_ack <= 1'b0;
      if (!dma_request || dma_ack) begin
        wait_r <= 4'h0;
      end else if (wait_r == delay) begin
        dma_ack <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the timer mode control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dmtm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin = 1'b1;
  logic pin_out;
  logic dma_request;
  logic irq_request;
  logic dma_ack;
  logic [3:0] delay = 4'h0;
  logic [32:0] notes[$];
  logic [7:0] psc;
  logic [31:0] rf;
  int errors = 0;
  int comparisons = 0;
  int n_dma = 0;
  int n_irq = 0;
  int k0;
  int k1;
  logic [7:0] ra[6] = '{A_MODE, A_XMODE, A_EVENT, A_REF, A_CAPT, A_CNT};
  logic [31:0] rv[6] = '{32'(MODE_RST), 32'(XMODE_RST), 32'h0,
    REF_RST, CAPT_RST, CNT_RST};
  always #2 pclk = ~pclk;
  dmtm_timer i_dmtm_timer (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_pin(pin),
    .timer_output_pin(pin_out), .dma_request(dma_request),
    .irq_request(irq_request), .dma_ack(dma_ack));
  dmtm_dma_model i_dmtm_dma_model (.pclk(pclk), .presetn(presetn),
    .dma_request(dma_request), .delay(delay), .dma_ack(dma_ack));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic fail_wait;
    errors++;
    give_verdict();
  endtask
  // read results pair with the oldest note
  always @(posedge pclk) begin
    if (dma_request === 1'b1) n_dma++;
    if (irq_request === 1'b1) n_irq++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (notes.size() == 0) check(33'h1, 33'h0);
      else check({pslverr, prdata}, notes.pop_front());
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_wait();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    notes.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic pulse_pin;
    pin <= 1'b0;
    cyc(6);
    pin <= 1'b1;
    cyc(6);
  endtask
  function automatic logic [31:0] md(input logic [7:0] p,
    input logic [1:0] ce, input logic sty, mreq, rsm,
    input logic [1:0] clk, input logic en);
    return {16'h0, p, ce, sty, mreq, rsm, clk, en};
  endfunction
  // interval between two output events, pulse width in style 0
  task automatic period(input logic om, input int exp);
    int t0;
    int ev;
    logic last;
    ev = 0;
    t0 = 0;
    last = pin_out;
    for (int k = 0; k < 3000 && ev < 2; k++) begin
      @(posedge pclk);
      #1;
      if (om ? pin_out !== last : last && !pin_out) begin
        if (ev == 1) check(33'(k - t0), 33'(exp));
        t0 = k;
        ev++;
      end
      if (!om && last === 1'b0) check(33'(pin_out), 33'h1);
      last = pin_out;
    end
    if (ev < 2) fail_wait();
  endtask
  initial begin
    void'($urandom(32'hbacb));
    cyc(2);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(ra[i], {1'b0, rv[i]});
    rd(8'h3C, {1'b1, 32'h0});
    wr(A_CNT, 32'h5);
    rd(A_CNT, 33'h0);
    wr(A_XMODE, 32'(XMODE_MASK));
    rd(A_XMODE, {25'h0, XMODE_MASK});
    wr(A_XMODE, 32'h0);
    // divider and restart timing over both styles and the sys1 and sys16 sources
    for (int i = 0; i < 4; i++) begin
      psc = 8'($urandom % 4);
      rf = 1 + $urandom % 4;
      wr(A_MODE, 32'h0);
      wr(A_REF, rf);
      wr(A_MODE, md(psc, CE_OFF, i[0], 1'b0, 1'b1,
        i[1] ? CLK_SYS16 : CLK_SYS1, 1'b1));
      period(i[0], (rf + 1) * (psc + 1) * (i[1] ? 16 : 1));
    end
    wr(A_MODE, 32'h0);
    // every capture edge code, falling then rising
    for (int c = 0; c < 4; c++) begin
      wr(A_MODE, md(8'h0, 2'(c), 1'b0, 1'b0, 1'b0, CLK_STOP, 1'b1));
      wr(A_EVENT, 32'h3);
      pin <= 1'b0;
      cyc(8);
      check(33'(irq_request), 33'(c[1]));
      rd(A_EVENT, 33'(c[1]));
      wr(A_EVENT, 32'h1);
      pin <= 1'b1;
      cyc(8);
      rd(A_EVENT, 33'(c[0]));
    end
    // pin-fall counting, plain and wide step
    for (int d = 0; d < 2; d++) begin
      wr(A_MODE, 32'h0);
      wr(A_EVENT, 32'h3);
      wr(A_XMODE, 32'(d));
      wr(A_REF, 32'h0002_0002);
      wr(A_MODE, md(8'h0, CE_OFF, 1'b0, 1'b0, 1'b0, CLK_PIN, 1'b1));
      repeat (3) pulse_pin();
      rd(A_CNT, d ? 33'h0003_0003 : 33'h3);
      rd(A_EVENT, 33'(d * 2));
    end
    wr(A_MODE, md(8'h0, CE_OFF, 1'b0, 1'b0, 1'b0, CLK_SYS1, 1'b0));
    cyc(10);
    rd(A_CNT, 33'h0);
    // match requests to dma (prompt, slow ack), last one to interrupt
    wr(A_REF, 32'h8);
    for (int o = 0; o < 4; o++) begin
      wr(A_MODE, 32'h0);
      wr(A_EVENT, 32'h3);
      wr(A_XMODE, o == 3 ? 32'h0 : 32'h80);
      delay <= o == 2 ? 4'h9 : 4'h0;
      k0 = n_dma;
      k1 = n_irq;
      wr(A_MODE, md(8'h0, CE_OFF, 1'b0, o != 0, 1'b0, CLK_SYS1, 1'b1));
      cyc(40);
      check(33'(n_dma > k0), 33'(o == 1 || o == 2));
      check(33'(n_irq > k1), 33'(o == 3));
      rd(A_EVENT, {31'h0, o == 0 || o == 3, 1'b0});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
